// *** src/i2c_slave10.v ***
// Two-wire bus slave with ten-bit address and general call recognition
`timescale 1ns/1ps
`include "i2c_slave10_regs.vh"
// Notes on behaviour
// - Ten-bit header is 11110, two MSBs, direction
// - Headers 11111XX are reserved, never matched
// - Direction low is write, high is read
// - Write header: next byte is low address
// - Header with write direction matched and acknowledged
// - Second byte must match low eight bits
// - Selection holds until stop or other address
// - Remembered selection plus read header makes transmitter
// - Read header without prior selection is ignored
// - Each byte gets one acknowledge slot
// - Any start resets protocol to address phase
// - Follows fast mode, may stretch clock low
// - Works equally at standard mode rates
// - Spikes on clock and data filtered
// - General call treated as seven-bit slave does
// - Start byte never acknowledged, restart follows
module i2c_slave10 (
  input wire ref_clk,
  input wire reset,
  input wire [9:0] own_addr,
  input wire gen_call_en,
  input wire scl_in,
  output wire scl_out,
  output wire scl_oe_n,
  input wire sda_in,
  output wire sda_out,
  output wire sda_oe_n,
  output reg [7:0] rx_data,
  output reg rx_valid,
  output reg rx_gen_call,
  input wire [7:0] tx_data,
  output reg tx_req,
  input wire tx_ready,
  output reg selected,
  output reg transmitting,
  output reg bus_stop
);
  // ---------------------------------------------------------------
  // States
  // ---------------------------------------------------------------
  localparam ST_IDLE = 3'd0;
  localparam ST_HDR = 3'd1;
  localparam ST_LOW = 3'd2;
  localparam ST_RXD = 3'd3;
  localparam ST_TXD = 3'd4;
  localparam ST_ACK = 3'd5;
  localparam ST_MACK = 3'd6;

  function is_ten_hdr;
    input [7:0] b;
    begin
      is_ten_hdr = (b[7:3] == `TEN_BIT_PREFIX);
    end
  endfunction

  // ---------------------------------------------------------------
  // Input conditioning
  // ---------------------------------------------------------------
  reg scl_s1_reg, scl_s2_reg, sda_s1_reg, sda_s2_reg;
  wire scl_f, sda_f;
  reg scl_d_reg, sda_d_reg;

  always @(posedge ref_clk) begin
    if (reset) begin
      scl_s1_reg <= 1'b1;
      scl_s2_reg <= 1'b1;
      sda_s1_reg <= 1'b1;
      sda_s2_reg <= 1'b1;
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_s1_reg <= scl_in;
      scl_s2_reg <= scl_s1_reg;
      sda_s1_reg <= sda_in;
      sda_s2_reg <= sda_s1_reg;
      scl_d_reg <= scl_f;
      sda_d_reg <= sda_f;
    end
  end

  glitch_filter scl_filt (
    .ref_clk(ref_clk),
    .reset(reset),
    .din(scl_s2_reg),
    .dout(scl_f)
  );
  glitch_filter sda_filt (
    .ref_clk(ref_clk),
    .reset(reset),
    .din(sda_s2_reg),
    .dout(sda_f)
  );

  wire scl_rise = scl_f & ~scl_d_reg;
  wire scl_fall = ~scl_f & scl_d_reg;
  wire start_det = scl_f & scl_d_reg & ~sda_f & sda_d_reg;
  wire stop_det = scl_f & scl_d_reg & sda_f & ~sda_d_reg;

  // ---------------------------------------------------------------
  // Protocol engine
  // ---------------------------------------------------------------
  reg [2:0] state_reg;
  reg [2:0] bit_cnt_reg;
  reg [7:0] shift_reg;
  reg hdr_hit_reg;
  reg remembered_reg;
  reg sda_low_reg;
  reg ack_pend_reg;
  reg ack_ok_reg;
  reg stretch_reg;
  reg [3:0] hold_reg;

  assign sda_out = 1'b0;
  assign scl_out = 1'b0;
  assign sda_oe_n = ~sda_low_reg;
  assign scl_oe_n = ~stretch_reg;

  wire [7:0] rx_byte = {shift_reg[6:0], sda_f};

  always @(posedge ref_clk) begin
    if (reset) begin
      state_reg <= ST_IDLE;
      bit_cnt_reg <= 3'h0;
      shift_reg <= 8'h0_0;
      hdr_hit_reg <= 1'b0;
      remembered_reg <= 1'b0;
      sda_low_reg <= 1'b0;
      ack_pend_reg <= 1'b0;
      ack_ok_reg <= 1'b0;
      stretch_reg <= 1'b0;
      hold_reg <= 4'h0;
      rx_data <= 8'h0_0;
      rx_valid <= 1'b0;
      rx_gen_call <= 1'b0;
      tx_req <= 1'b0;
      selected <= 1'b0;
      transmitting <= 1'b0;
      bus_stop <= 1'b0;
    end else begin
      rx_valid <= 1'b0;
      tx_req <= 1'b0;
      bus_stop <= 1'b0;
      if (stop_det) begin
        state_reg <= ST_IDLE;
        remembered_reg <= 1'b0;
        selected <= 1'b0;
        transmitting <= 1'b0;
        sda_low_reg <= 1'b0;
        stretch_reg <= 1'b0;
        bus_stop <= 1'b1;
        // Selection by general call ends with the transfer
        rx_gen_call <= 1'b0;
      end else if (start_det) begin
        state_reg <= ST_HDR;
        bit_cnt_reg <= 3'h0;
        sda_low_reg <= 1'b0;
        stretch_reg <= 1'b0;
        transmitting <= 1'b0;
      end else begin
        case (state_reg)
          ST_IDLE: begin
            sda_low_reg <= 1'b0;
          end
          ST_HDR, ST_LOW, ST_RXD: begin
            if (scl_rise) begin
              shift_reg <= rx_byte;
              if (bit_cnt_reg == `BIT_COUNT_LAST) begin
                bit_cnt_reg <= 3'h0;
                ack_pend_reg <= 1'b1;
                ack_ok_reg <= 1'b0;
                if (state_reg == ST_HDR) begin
                  // Any new address deselects until it matches again
                  selected <= 1'b0;
                  rx_gen_call <= 1'b0;
                  // A stale header hit would send the next data byte to the low-address match
                  hdr_hit_reg <= 1'b0;
                  if (is_ten_hdr(rx_byte) && (rx_byte[2:1] == own_addr[9:8])) begin
                    if (!rx_byte[0]) begin
                      hdr_hit_reg <= 1'b1;
                      ack_ok_reg <= 1'b1;
                      remembered_reg <= 1'b0;
                    end else if (remembered_reg) begin
                      ack_ok_reg <= 1'b1;
                      selected <= 1'b1;
                      transmitting <= 1'b1;
                    end else begin
                      hdr_hit_reg <= 1'b0;
                    end
                  end else if (gen_call_en && rx_byte[7:1] == `GENERAL_CALL_ADDR && !rx_byte[0]) begin
                    ack_ok_reg <= 1'b1;
                    selected <= 1'b1;
                    rx_gen_call <= 1'b1;
                    remembered_reg <= 1'b0;
                  end else begin
                    // Start byte, seven-bit or reserved headers land here
                    remembered_reg <= 1'b0;
                    hdr_hit_reg <= 1'b0;
                  end
                end else if (state_reg == ST_LOW) begin
                  if (hdr_hit_reg && rx_byte == own_addr[7:0]) begin
                    ack_ok_reg <= 1'b1;
                    selected <= 1'b1;
                    remembered_reg <= 1'b1;
                  end
                  hdr_hit_reg <= 1'b0;
                end else begin
                  ack_ok_reg <= 1'b1;
                  rx_data <= rx_byte;
                  rx_valid <= 1'b1;
                end
              end else begin
                bit_cnt_reg <= bit_cnt_reg + 3'h1;
              end
            end
            if (scl_fall && ack_pend_reg) begin
              ack_pend_reg <= 1'b0;
              sda_low_reg <= ack_ok_reg;
              if (ack_ok_reg) begin
                state_reg <= ST_ACK;
              end else begin
                state_reg <= ST_IDLE;
              end
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              sda_low_reg <= 1'b0;
              if (transmitting) begin
                tx_req <= 1'b1;
                stretch_reg <= 1'b1;
                hold_reg <= `STRETCH_CYCLES;
                state_reg <= ST_TXD;
              end else if (hdr_hit_reg) begin
                state_reg <= ST_LOW;
              end else begin
                state_reg <= ST_RXD;
              end
            end
          end
          ST_TXD: begin
            if (stretch_reg) begin
              if (hold_reg != 4'h0) begin
                hold_reg <= hold_reg - 4'h1;
              end else if (tx_ready) begin
                shift_reg <= tx_data;
                sda_low_reg <= ~tx_data[7];
                bit_cnt_reg <= 3'h0;
                stretch_reg <= 1'b0;
              end
            end else if (scl_fall) begin
              if (bit_cnt_reg == `BIT_COUNT_LAST) begin
                sda_low_reg <= 1'b0;
                state_reg <= ST_MACK;
              end else begin
                sda_low_reg <= ~shift_reg[6];
                shift_reg <= {shift_reg[6:0], 1'b0};
                bit_cnt_reg <= bit_cnt_reg + 3'h1;
              end
            end
          end
          ST_MACK: begin
            if (scl_rise) begin
              if (sda_f) begin
                state_reg <= ST_IDLE;
                transmitting <= 1'b0;
              end else begin
                state_reg <= ST_ACK;
              end
            end
          end
          default: begin
            state_reg <= ST_IDLE;
          end
        endcase
      end
    end
  end
endmodule

// *** src/i2c_slave10_regs.vh ***
// Constants for the ten-bit address two-wire bus slave
`ifndef I2C_SLAVE10_REGS_VH
`define I2C_SLAVE10_REGS_VH
`define TEN_BIT_PREFIX 5'h1_E
`define RESERVED_PREFIX 5'h1_F
`define GENERAL_CALL_ADDR 7'h0_0
`define START_BYTE_VAL 8'h0_1
`define BIT_COUNT_LAST 3'h7
`define FILTER_LEN 2'h2
`define STRETCH_CYCLES 4'h2
`endif

// *** src/glitch_filter.v ***
// Majority-free spike filter: output follows input only after it stays stable
`timescale 1ns/1ps
`include "i2c_slave10_regs.vh"
module glitch_filter (
  input wire ref_clk,
  input wire reset,
  input wire din,
  output reg dout
);
  reg [1:0] count_reg;

  // A level must persist FILTER_LEN+1 samples (150 ns) before it passes
  always @(posedge ref_clk) begin
    if (reset) begin
      count_reg <= 2'h0;
      dout <= 1'b1;
    end else if (din == dout) begin
      count_reg <= 2'h0;
    end else if (count_reg == `FILTER_LEN) begin
      count_reg <= 2'h0;
      dout <= din;
    end else begin
      count_reg <= count_reg + 2'h1;
    end
  end
endmodule

// *** verification/i2c_slave10_chk.sv ***
// Assertion checker for the ten-bit address bus slave
`timescale 1ns/1ps
module i2c_slave10_chk (
  input wire ref_clk,
  input wire reset,
  input wire gen_call_en,
  input wire scl_out,
  input wire scl_oe_n,
  input wire sda_out,
  input wire rx_valid,
  input wire rx_gen_call,
  input wire tx_req,
  input wire selected,
  input wire transmitting,
  input wire bus_stop
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  property p_drain; !scl_out && !sda_out; endproperty
  a_drain: assert property (p_drain) else $error("line driven high");
  property p_hold; tx_req |-> !scl_oe_n ##1 !scl_oe_n ##1 !scl_oe_n; endproperty
  a_hold: assert property (p_hold) else $error("clock not held");
  property p_txsel; tx_req |-> transmitting && selected; endproperty
  a_txsel: assert property (p_txsel) else $error("byte wanted unselected");
  property p_pulse; rx_valid |=> !rx_valid; endproperty
  a_pulse: assert property (p_pulse) else $error("rx pulse too long");
  property p_rxsel; rx_valid |-> selected && !transmitting; endproperty
  a_rxsel: assert property (p_rxsel) else $error("rx while not receiver");
  property p_gc; rx_gen_call |-> gen_call_en; endproperty
  a_gc: assert property (p_gc) else $error("general call disabled");
  property p_stop; bus_stop |-> ##[0:3] !selected; endproperty
  a_stop: assert property (p_stop) else $error("kept after stop");
  property p_txrise; $rose(transmitting) |-> selected; endproperty
  a_txrise: assert property (p_txrise) else $error("transmit unselected");
endmodule
bind i2c_slave10 i2c_slave10_chk chk (.ref_clk, .reset, .gen_call_en, .scl_out, .scl_oe_n, .sda_out,
  .rx_valid, .rx_gen_call, .tx_req, .selected, .transmitting, .bus_stop);

// *** verification/bus_master.sv ***
// Bus master model driving clock and data as open drain
`timescale 1ns/1ps
module bus_master (
  input wire clk,
  input wire scl,
  input wire sda,
  output reg scl_o,
  output reg sda_o
);
  // Quarter bit in clocks: 13 gives about 385 kbit/s
  integer n = 13;
  initial begin
    scl_o = 1;
    sda_o = 1;
  end
  task w;
    begin
      repeat (n) @(posedge clk);
      #1;
    end
  endtask
  task bitx(input b, output r);
    begin
      w;
      sda_o = b;
      w;
      scl_o = 1;
      wait (scl);
      w;
      r = sda;
      w;
      scl_o = 0;
    end
  endtask
  task start;
    begin
      w;
      sda_o = 1;
      w;
      scl_o = 1;
      wait (scl);
      w;
      sda_o = 0;
      w;
      scl_o = 0;
    end
  endtask
  task stop;
    begin
      w;
      sda_o = 0;
      w;
      scl_o = 1;
      w;
      sda_o = 1;
      w;
    end
  endtask
  task spike;
    begin
      w;
      scl_o = 1;
      #50 scl_o = 0;
    end
  endtask
  // Ack slot is released by the sender so the receiver can pull it
  task xbyte(input [7:0] d, input a, output [8:0] r);
    integer i;
    begin
      for (i = 8; i > 0; i = i - 1)
        bitx(d[i-1], r[i]);
      bitx(a, r[0]);
    end
  endtask
endmodule

// *** verification/i2c_slave10_tb.sv ***
// Self-checking bench for the ten-bit address bus slave
`timescale 1ns/1ps
module i2c_slave10_tb;
  reg ref_clk = 0;
  reg reset = 1;
  reg gen_call_en = 0;
  reg tx_ready = 0;
  wire scl_o, sda_o, scl_out, scl_oe_n, sda_out, sda_oe_n;
  wire [7:0] rx_data;
  wire rx_valid, rx_gen_call, tx_req, selected, transmitting, bus_stop;
  wire scl = scl_o & scl_oe_n;
  wire sda = sda_o & sda_oe_n;
  reg [8:0] r;
  reg [7:0] bad [0:3];
  integer fails = 0;
  integer num_checks = 0;
  integer k;
  integer rx_count = 0;
  integer stop_count = 0;
  i2c_slave10 dut (.ref_clk, .reset, .own_addr(10'h2A5), .gen_call_en, .scl_in(scl), .scl_out, .scl_oe_n,
    .sda_in(sda), .sda_out, .sda_oe_n, .rx_data, .rx_valid, .rx_gen_call, .tx_data(8'h96), .tx_req, .tx_ready,
    .selected, .transmitting, .bus_stop);
  bus_master m (.clk(ref_clk), .scl, .sda, .scl_o, .sda_o);
  always @(posedge ref_clk) tx_ready <= #1 tx_req | (tx_ready & transmitting);
  // One-cycle pulses are counted as they occur
  always @(posedge ref_clk) begin
    if (rx_valid === 1'b1) begin
      rx_count <= rx_count + 1;
    end
    if (bus_stop === 1'b1) begin
      stop_count <= stop_count + 1;
    end
  end
  task check(input string nm, input [8:0] seen, input [8:0] exp);
    begin
      num_checks = num_checks + 1;
      if (seen !== exp) begin
        fails = fails + 1;
        $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task final_report;
    begin
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
  task t_write_read;
    begin
      m.start;
      m.xbyte(8'hF4, 1, r);
      check("hdr ack", r[0], 0);
      m.xbyte(8'hA5, 1, r);
      check("low ack", r[0], 0);
      check("selected", selected, 1);
      m.spike;
      m.xbyte(8'h3C, 1, r);
      check("rx_data", rx_data, 8'h3C);
      check("rx pulses", rx_count[8:0], 9'h001);
      m.start;
      m.xbyte(8'hF5, 1, r);
      check("read ack", r[0], 0);
      check("transmitting", transmitting, 1);
      m.xbyte(8'hFF, 0, r);
      check("tx byte", r[8:1], 8'h96);
      m.xbyte(8'hFF, 1, r);
      check("tx byte 2", r[8:1], 8'h96);
      m.stop;
      check("deselect", selected, 0);
      check("stops", stop_count[8:0], 9'h001);
    end
  endtask
  task t_low;
    begin
      m.start;
      m.xbyte(8'hF4, 1, r);
      m.xbyte(8'hA4, 1, r);
      check("low nack", r[0], 1);
      m.start;
      m.xbyte(8'hF5, 1, r);
      check("no read", r[0], 1);
      m.stop;
    end
  endtask
  task t_refuse;
    begin
      bad[0] = 8'hF5;
      bad[1] = 8'hFC;
      bad[2] = 8'h01;
      bad[3] = 8'hF0;
      for (k = 0; k < 4; k = k + 1) begin
        m.start;
        m.xbyte(bad[k], 1, r);
        check("refused", r[0], 1);
        m.stop;
      end
    end
  endtask
  task t_gen_call;
    begin
      for (k = 0; k < 2; k = k + 1) begin
        gen_call_en = k[0];
        m.start;
        m.xbyte(8'h00, 1, r);
        check("gc ack", r[0], !k[0]);
        check("gc sel", rx_gen_call, k[0]);
        m.stop;
        check("gc clear", rx_gen_call, 0);
      end
    end
  endtask
  task t_slow;
    begin
      m.n = 50;
      m.start;
      m.xbyte(8'hF4, 1, r);
      m.xbyte(8'hA5, 1, r);
      check("slow ack", r[0], 0);
      m.stop;
      m.n = 13;
    end
  endtask
  initial begin
    forever #25 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (5) @(posedge ref_clk);
    #1 reset = 0;
    t_write_read;
    t_low;
    t_refuse;
    t_gen_call;
    t_slow;
    final_report;
  end
  initial begin
    #3000000;
    fails = fails + 1;
    final_report;
  end
endmodule
